// *** common/limiter_defines.svh ***
// Constants for the output frequency limiter and stall selection decoder
// How it works
// - Command above maximum setting outputs the maximum setting instead.
// - Maximum setting is the upper limit, range 0..120 Hz, resets to 120 Hz.
// - Set frequency below minimum setting outputs the minimum setting.
// - Minimum setting is the lower limit, range 0..120 Hz, resets to 0 Hz.
// - High-speed maximum ranges 120..400 Hz, resets to 120 Hz.
// - Writing high-speed maximum also loads the maximum setting.
// - Writing maximum setting also loads the high-speed maximum.
// - High-speed maximum is writable only while user group read select is zero.
// - Codes 14, 15, 30, 31 never raise the overload flag or trip fault.
// - Codes 100/101 follow driving or regeneration; regeneration turns all limits off.
// - Code 101 in driving: fast limit off, stall prevention on in all phases.
// - Codes 0..31 are bit flags: fast off, phase offs, stop on overload.
// - Overload flag holds longer than 100 ms, then drops when current recovers.
// - Jog setting at or below the minimum setting overrides the minimum clamp.
`ifndef LIMITER_DEFINES_SVH
`define LIMITER_DEFINES_SVH

// Frequencies in 0.01 Hz steps
`define MAX_FREQ_RST   16'h2ee0
`define MIN_FREQ_RST   16'h0000
`define LOW_RANGE_TOP  16'h2ee0
`define HS_RANGE_BOT   16'h2ee0
`define HS_RANGE_TOP   16'h9c40
`define TRIP_FREQ      16'h0064

// Stall selection codes and flag positions
`define SEL_RST        8'h00
`define SEL_FLAG_TOP   8'h1f
`define SEL_SPLIT      8'h64
`define SEL_SPLIT_FAST 8'h65
`define SEL_FAST_OFF   0
`define SEL_ACC_OFF    1
`define SEL_CON_OFF    2
`define SEL_DEC_OFF    3
`define SEL_OL_STOP    4
`define UGRS_OPEN      16'h0000

// Timing
`define CLK_HZ         10000000
`define OL_HOLD_MS     100
`define TRIP_S         3
`define OL_HOLD_CYC    ((`OL_HOLD_MS * `CLK_HZ) / 1000 + 1)
`define TRIP_CYC       (`TRIP_S * `CLK_HZ)

`endif

// *** common/limiter_pkg.sv ***
// Types shared by the frequency limiter modules
package limiter_pkg;

	typedef logic [15:0] freq_t;
	typedef logic [7:0]  sel_t;

	typedef enum logic [1:0] {
		OL_IDLE = 2'b01,
		OL_ON   = 2'b10
	} ol_state_t;

	typedef struct packed {
		freq_t max_f;
		freq_t min_f;
		freq_t hs_f;
		sel_t  sel;
		freq_t out_f;
		logic  refused;
	} lim_state_t;

	typedef struct packed {
		ol_state_t   st;
		logic [31:0] hold;
		logic [31:0] low;
		logic        trip;
	} mon_state_t;

endpackage

// *** src/stall_select_decoder.sv ***
// Decodes the stall selection code into per-phase enables
`timescale 1ns/1ps
`include "limiter_defines.svh"

module stall_select_decoder
(
	input  wire limiter_pkg::sel_t sel,
	input  wire logic              regen,
	input  wire logic              accel,
	input  wire logic              decel,
	output logic                   fast_limit_en,
	output logic                   stall_phase_en,
	output logic                   ol_continue
);
	import limiter_pkg::*;

	logic acc_en;
	logic con_en;
	logic dec_en;

	// Split codes follow the drive mode, plain codes are bit flags
	always_comb
	begin
		if (sel == `SEL_SPLIT || sel == `SEL_SPLIT_FAST)
		begin
			fast_limit_en = !regen && (sel == `SEL_SPLIT);
			acc_en        = !regen;
			con_en        = !regen;
			dec_en        = !regen;
			ol_continue   = 1'b1;
		end
		else
		begin
			fast_limit_en = !sel[`SEL_FAST_OFF];
			acc_en        = !sel[`SEL_ACC_OFF];
			con_en        = !sel[`SEL_CON_OFF];
			dec_en        = !sel[`SEL_DEC_OFF];
			ol_continue   = !sel[`SEL_OL_STOP];
		end
		stall_phase_en = accel ? acc_en : (decel ? dec_en : con_en);
	end

endmodule

// *** src/overload_monitor.sv ***
// Overload stall flag with minimum hold and low-frequency trip
`timescale 1ns/1ps
`include "limiter_defines.svh"

module overload_monitor
#(
	parameter int unsigned HOLD_CYC = `OL_HOLD_CYC,
	parameter int unsigned TRIP_CYC = `TRIP_CYC
)
(
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 stall_on,
	input  wire limiter_pkg::freq_t   out_freq,
	input  wire logic                 fault_clear,
	output logic                      overload_stall_flag,
	output logic                      stall_trip_fault
);
	import limiter_pkg::*;

	mon_state_t s_q;
	mon_state_t s_d;

	// Flag holds at least HOLD_CYC cycles, trip needs TRIP_CYC low cycles
	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			OL_IDLE:
			begin
				if (stall_on)
				begin
					s_d.st   = OL_ON;
					s_d.hold = 32'h0000_0001;
				end
			end
			OL_ON:
			begin
				if (s_q.hold < HOLD_CYC)
					s_d.hold = s_q.hold + 32'h0000_0001;
				else if (!stall_on)
				begin
					s_d.st   = OL_IDLE;
					s_d.hold = 32'h0000_0000;
				end
			end
			default:
				s_d.st = OL_IDLE;
		endcase
		if (s_q.st == OL_ON && out_freq <= `TRIP_FREQ)
			s_d.low = s_q.low + 32'h0000_0001;
		else
			s_d.low = 32'h0000_0000;
		// Set wins over a clear in the same cycle
		if (fault_clear)
			s_d.trip = 1'b0;
		if (s_q.st == OL_ON && out_freq <= `TRIP_FREQ && s_q.low >= TRIP_CYC - 1)
			s_d.trip = 1'b1;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s_q.st   <= OL_IDLE;
			s_q.hold <= 32'h0000_0000;
			s_q.low  <= 32'h0000_0000;
			s_q.trip <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign overload_stall_flag = (s_q.st == OL_ON);
	assign stall_trip_fault    = s_q.trip;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_flag_min_hold: assert property ($fell(overload_stall_flag) |->
		$past(s_q.hold) >= HOLD_CYC && !$past(stall_on))
		else $error("overload flag dropped before hold time");

	a_trip_cause: assert property ($rose(stall_trip_fault) |->
		$past(overload_stall_flag) && $past(out_freq) <= `TRIP_FREQ)
		else $error("trip raised without overload at low frequency");

endmodule

// *** src/output_frequency_limiter.sv ***
// Output frequency clamp, limit settings and stall selection
`timescale 1ns/1ps
`include "limiter_defines.svh"

module output_frequency_limiter
#(
	parameter int unsigned HOLD_CYC = `OL_HOLD_CYC,
	parameter int unsigned TRIP_CYC = `TRIP_CYC
)
(
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire limiter_pkg::freq_t   freq_cmd,
	input  wire logic                 jog_active,
	input  wire limiter_pkg::freq_t   jog_freq_setting,
	input  wire limiter_pkg::freq_t   wr_data,
	input  wire logic                 wr_max,
	input  wire logic                 wr_min,
	input  wire logic                 wr_hs_max,
	input  wire logic                 wr_sel,
	input  wire limiter_pkg::freq_t   user_group_read_select,
	input  wire logic                 regen,
	input  wire logic                 accel,
	input  wire logic                 decel,
	input  wire logic                 current_over,
	input  wire logic                 fault_clear,
	output limiter_pkg::freq_t        out_freq,
	output limiter_pkg::freq_t        max_freq_setting,
	output limiter_pkg::freq_t        min_freq_setting,
	output limiter_pkg::freq_t        high_speed_max_setting,
	output limiter_pkg::sel_t         stall_select_code,
	output logic                      wr_refused,
	output logic                      fast_limit_en,
	output logic                      stall_phase_en,
	output logic                      ol_continue,
	output logic                      overload_stall_flag,
	output logic                      stall_trip_fault
);
	import limiter_pkg::*;

	lim_state_t s_q;
	lim_state_t s_d;
	freq_t      clamped;
	logic       sel_ok;
	logic       stall_on;

	////////////////////////////////////////////////////////////////////////
	// Frequency clamp

	// Max clamp first, then min; a low jog setting bypasses the min clamp
	always_comb
	begin
		clamped = freq_cmd;
		if (jog_active && jog_freq_setting <= s_q.min_f)
		begin
			clamped = jog_freq_setting;
			if (clamped > s_q.max_f)
				clamped = s_q.max_f;
		end
		else
		begin
			if (clamped > s_q.max_f)
				clamped = s_q.max_f;
			if (clamped < s_q.min_f)
				clamped = s_q.min_f;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Setting writes

	// Selection codes 0..31 and the two split codes are legal
	assign sel_ok = (wr_data[15:8] == 8'h00) &&
		(wr_data[7:0] <= `SEL_FLAG_TOP || wr_data[7:0] == `SEL_SPLIT ||
		wr_data[7:0] == `SEL_SPLIT_FAST);

	// Out-of-range or locked writes are dropped and flagged for one cycle
	always_comb
	begin
		s_d         = s_q;
		s_d.out_f   = clamped;
		s_d.refused = 1'b0;
		if (wr_max)
		begin
			if (wr_data <= `LOW_RANGE_TOP)
			begin
				s_d.max_f = wr_data;
				s_d.hs_f  = wr_data;
			end
			else
				s_d.refused = 1'b1;
		end
		if (wr_min)
		begin
			if (wr_data <= `LOW_RANGE_TOP)
				s_d.min_f = wr_data;
			else
				s_d.refused = 1'b1;
		end
		if (wr_hs_max)
		begin
			if (user_group_read_select == `UGRS_OPEN &&
				wr_data >= `HS_RANGE_BOT && wr_data <= `HS_RANGE_TOP)
			begin
				s_d.hs_f  = wr_data;
				s_d.max_f = wr_data;
			end
			else
				s_d.refused = 1'b1;
		end
		if (wr_sel)
		begin
			if (sel_ok)
				s_d.sel = wr_data[7:0];
			else
				s_d.refused = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s_q.max_f   <= `MAX_FREQ_RST;
			s_q.min_f   <= `MIN_FREQ_RST;
			s_q.hs_f    <= `MAX_FREQ_RST;
			s_q.sel     <= `SEL_RST;
			s_q.out_f   <= `MIN_FREQ_RST;
			s_q.refused <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	// Registered outputs
	assign out_freq               = s_q.out_f;
	assign max_freq_setting       = s_q.max_f;
	assign min_freq_setting       = s_q.min_f;
	assign high_speed_max_setting = s_q.hs_f;
	assign stall_select_code      = s_q.sel;
	assign wr_refused             = s_q.refused;

	////////////////////////////////////////////////////////////////////////
	// Stall selection and overload

	stall_select_decoder u_dec
	(
		.sel            (s_q.sel),
		.regen          (regen),
		.accel          (accel),
		.decel          (decel),
		.fast_limit_en  (fast_limit_en),
		.stall_phase_en (stall_phase_en),
		.ol_continue    (ol_continue)
	);

	// Stall only counts in a phase where prevention is enabled
	assign stall_on = stall_phase_en && current_over;

	overload_monitor #(
		.HOLD_CYC (HOLD_CYC),
		.TRIP_CYC (TRIP_CYC)
	) u_mon
	(
		.clk                 (clk),
		.resetn              (resetn),
		.stall_on            (stall_on),
		.out_freq            (s_q.out_f),
		.fault_clear         (fault_clear),
		.overload_stall_flag (overload_stall_flag),
		.stall_trip_fault    (stall_trip_fault)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_cmd_over;
		!jog_active && freq_cmd > s_q.max_f && s_q.max_f >= s_q.min_f;
	endsequence

	sequence s_cmd_under;
		!jog_active && freq_cmd < s_q.min_f;
	endsequence

	sequence s_hs_write;
		wr_hs_max && !wr_sel && user_group_read_select == `UGRS_OPEN &&
		wr_data >= `HS_RANGE_BOT && wr_data <= `HS_RANGE_TOP;
	endsequence

	sequence s_max_write;
		wr_max && !wr_hs_max && wr_data <= `LOW_RANGE_TOP;
	endsequence

	a_max_clamp: assert property (s_cmd_over |=> out_freq == $past(s_q.max_f))
		else $error("command above maximum was not clamped");

	a_min_clamp: assert property (s_cmd_under |=> out_freq == $past(s_q.min_f))
		else $error("command below minimum was not clamped");

	a_out_bounds: assert property (##1 !$past(jog_active) |->
		out_freq <= $past(s_q.max_f) || out_freq == $past(s_q.min_f))
		else $error("output exceeds maximum setting");

	a_jog_first: assert property (jog_active && jog_freq_setting <= s_q.min_f &&
		jog_freq_setting <= s_q.max_f |=> out_freq == $past(jog_freq_setting))
		else $error("low jog setting did not override minimum clamp");

	a_hs_mirror: assert property (s_hs_write |=>
		max_freq_setting == $past(wr_data) && high_speed_max_setting == $past(wr_data))
		else $error("high-speed write did not load maximum");

	a_max_mirror: assert property (s_max_write |=>
		high_speed_max_setting == $past(wr_data) && max_freq_setting == $past(wr_data))
		else $error("maximum write did not load high-speed maximum");

	a_hs_locked: assert property (user_group_read_select != `UGRS_OPEN && !wr_max |=>
		$stable(high_speed_max_setting))
		else $error("high-speed maximum changed while locked");

	a_all_off_quiet: assert property (s_q.sel[3:1] == 3'h7 && s_q.sel <= `SEL_FLAG_TOP
		|-> !stall_on)
		else $error("stall active with all phases disabled");

	a_regen_off: assert property ((s_q.sel == `SEL_SPLIT || s_q.sel == `SEL_SPLIT_FAST)
		&& regen |-> !fast_limit_en && !stall_phase_en)
		else $error("limits active in regeneration with split code");

	a_code_fast_off: assert property (s_q.sel == `SEL_SPLIT_FAST && !regen
		|-> !fast_limit_en && stall_phase_en)
		else $error("split fast code wrong in driving");

	a_flag_onset: assert property (!overload_stall_flag && stall_on |=>
		overload_stall_flag [*2])
		else $error("overload flag did not follow stall");

endmodule

// *** dv/cmd_source_model.sv ***
// Model of the frequency command source and the motor control core
`timescale 1ns/1ps

module cmd_source_model
(
	input  wire logic          clk,
	input  wire logic          force_over,
	output limiter_pkg::freq_t freq_cmd,
	output logic               regen,
	output logic               accel,
	output logic               decel,
	output logic               current_over
);
	import limiter_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Quiet start so every input is known at time zero
	initial
	begin
		freq_cmd = 16'h0000;
		{regen, accel, decel, current_over} = 4'h0;
	end

	// New command and motor state just after each edge, some above every limit
	always @(posedge clk)
	begin
		freq_cmd <= 16'($urandom % 32'ha000);
		regen <= ($urandom % 4) == 0;
		accel <= 1'($urandom % 2);
		decel <= 1'($urandom % 2);
		current_over <= force_over | (($urandom % 4) == 0); // Random stall one cycle in four, held on while force_over is set
	end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the output frequency limiter
`timescale 1ns/1ps
`include "limiter_defines.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
	import limiter_pkg::*;

	localparam int HOLD = 4;
	logic        clk = 0;
	logic        resetn = 0;
	logic [3:0]  wstb = 0;
	logic        jog_active = 0;
	logic        fault_clear = 0;
	logic        force_over = 0;
	logic        quiet = 0;
	freq_t       jog_f = 0;
	freq_t       wr_data = 0;
	freq_t       ugrs = 0;
	freq_t       freq_cmd, out_freq, max_f, min_f, hs_f;
	freq_t       mx, mn, hs, eo;
	sel_t        sel, code;
	logic        regen, accel, decel, current_over, refused, fast, ph, olc, flag, fault;
	logic        xf, xp, xo, eref, ok, pst, pflag, efault;
	int          hcnt, lcnt, cyc, failures, num_checks;
	localparam int TRIP = 6;
	localparam logic [15:0] QUIET [4] = '{16'h000e, 16'h000f, 16'h001e, 16'h001f};

	output_frequency_limiter #(.HOLD_CYC(HOLD), .TRIP_CYC(TRIP)) uut
	(
		.clk(clk), .resetn(resetn), .freq_cmd(freq_cmd), .jog_active(jog_active),
		.jog_freq_setting(jog_f), .wr_data(wr_data), .wr_max(wstb[0]), .wr_min(wstb[1]),
		.wr_hs_max(wstb[2]), .wr_sel(wstb[3]), .user_group_read_select(ugrs),
		.regen(regen), .accel(accel), .decel(decel), .current_over(current_over),
		.fault_clear(fault_clear), .out_freq(out_freq), .max_freq_setting(max_f),
		.min_freq_setting(min_f), .high_speed_max_setting(hs_f),
		.stall_select_code(code), .wr_refused(refused), .fast_limit_en(fast),
		.stall_phase_en(ph), .ol_continue(olc), .overload_stall_flag(flag),
		.stall_trip_fault(fault)
	);

	cmd_source_model src
	(
		.clk(clk), .force_over(force_over), .freq_cmd(freq_cmd), .regen(regen),
		.accel(accel), .decel(decel), .current_over(current_over)
	);

	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, one place for every way out
	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One setting write: k picks max, min, high-speed max or stall code
	task automatic wr(input int k, input logic [15:0] d);
		@(posedge clk);
		wstb <= 4'(1 << k);
		wr_data <= d;
		@(posedge clk);
		wstb <= 4'h0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reference model: compare last result, then predict from this edge's inputs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			failures++;
			report_and_stop();
		end
		if (sel > 8'd31)
		begin
			xf = !regen && sel == 8'd100;
			xp = !regen;
			xo = 1'b1;
		end
		else
		begin
			xf = !sel[0];
			xp = accel ? !sel[1] : (decel ? !sel[3] : !sel[2]);
			xo = !sel[4];
		end
		if (!resetn)
		begin
			{mx, mn, hs, sel, eo} = {16'h2ee0, 16'h0000, 16'h2ee0, 8'h00, 16'h0000};
			{eref, pst, pflag, hcnt, efault, lcnt} = 0;
		end
		else
		begin
			`CHK("out_freq", eo, out_freq)
			`CHK("max_freq_setting", mx, max_f)
			`CHK("min_freq_setting", mn, min_f)
			`CHK("high_speed_max_setting", hs, hs_f)
			`CHK("stall_select_code", sel, code)
			`CHK("wr_refused", eref, refused)
			`CHK("fast_limit_en", xf, fast)
			`CHK("stall_phase_en", xp, ph)
			if (sel[3:1] != 3'b111)
				`CHK("ol_continue", xo, olc)
			if (!pflag)
				`CHK("overload_stall_flag", pst, flag)
			if (pflag && !flag)
				`CHK("flag_hold", 1'b1, hcnt >= HOLD)
			if (quiet)
				`CHK("stall_trip_fault", 1'b0, fault)
			`CHK("trip_fault", efault, fault)
			// Trip after TRIP flagged low-frequency cycles, set wins over clear
			efault = (fault_clear ? 1'b0 : efault) |
				(flag && out_freq <= `TRIP_FREQ && lcnt >= TRIP - 1);
			lcnt = (flag && out_freq <= `TRIP_FREQ) ? lcnt + 1 : 0;
			hcnt = flag ? hcnt + 1 : 0;
			pflag = flag;
			pst = xp && current_over;
			eo = (freq_cmd < mx) ? freq_cmd : mx;
			eo = (eo < mn) ? mn : eo;
			if (jog_active && jog_f <= mn)
				eo = (jog_f < mx) ? jog_f : mx;
			eref = 1'b0;
			ok = wr_data <= `LOW_RANGE_TOP;
			if (wstb[0])
				{eref, mx, hs} = ok ? {1'b0, wr_data, wr_data} : {1'b1, mx, hs};
			if (wstb[1])
				{eref, mn} = ok ? {1'b0, wr_data} : {1'b1, mn};
			ok = ugrs == 0 && wr_data >= `HS_RANGE_BOT && wr_data <= `HS_RANGE_TOP;
			if (wstb[2])
				{eref, mx, hs} = ok ? {1'b0, wr_data, wr_data} : {1'b1, mx, hs};
			ok = wr_data <= 16'd31 || wr_data == 16'd100 || wr_data == 16'd101;
			if (wstb[3])
				{eref, sel} = ok ? {1'b0, wr_data[7:0]} : {1'b1, sel};
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Boundary writes, every stall code, random traffic, then reset and quiet codes
	initial
	begin
		void'($urandom(75));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		wr(0, 16'h2ee1);
		wr(0, 16'h1388);
		wr(1, 16'h0fa0);
		wr(1, 16'h2000);
		wr(1, 16'h2ee1);
		wr(2, 16'h9c40);
		wr(2, 16'h9c41);
		wr(2, 16'h2edf);
		ugrs <= 16'h0001;
		wr(2, 16'h3000);
		ugrs <= 16'h0000;
		wr(0, 16'h2ee0);
		wr(1, 16'h0000);
		for (int c = 0; c < 36; c++)
		begin
			wr(3, (c < 32) ? 16'(c) : (c == 32) ? 16'd100 : (c == 33) ? 16'd101 :
				(c == 34) ? 16'd102 : 16'h0105);
			repeat (12) @(posedge clk);
		end
		repeat (400)
		begin
			@(posedge clk);
			wstb <= 4'(1 << ($urandom % 8));
			wr_data <= 16'($urandom % 32'ha000);
			ugrs <= (($urandom % 4) == 0) ? 16'($urandom) : 16'h0000;
			jog_active <= 1'($urandom % 2);
			jog_f <= 16'($urandom % 32'h1000);
			fault_clear <= ($urandom % 32) == 0;
		end
		// Low jog at the minimum while stalled drives the trip, then clear it
		wr(0, 16'h2ee0);
		wr(1, 16'h0032);
		wr(3, 16'h0000);
		jog_active <= 1'b1;
		jog_f <= 16'h0032;
		force_over <= 1'b1;
		fault_clear <= 1'b0;
		repeat (12) @(posedge clk);
		jog_active <= 1'b0;
		force_over <= 1'b0;
		repeat (8) @(posedge clk);
		fault_clear <= 1'b1;
		@(posedge clk);
		fault_clear <= 1'b0;
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		quiet <= 1'b1;
		force_over <= 1'b1;
		// All-phase-off codes; the odd ones keep the fast limit off for lifts
		for (int c = 0; c < 4; c++)
		begin
			wr(3, QUIET[c]);
			repeat (15) @(posedge clk);
		end
		report_and_stop();
	end
endmodule
